// ---- wbfbq_pkg.sv ----
/*
  Constants, register map and shared arithmetic for the wideband final
  decimator and biquad filter block.
  Assumes a 50 MHz master clock and 24-bit signed sample data.
*/
package wbfbq_pkg;

  localparam int DATA_W = 24;
  localparam int COEF_W = 32;
  localparam int IIR_FRAC = 30;
  localparam int FIR_FRAC = 31;
  localparam int N_TAPS = 136;
  localparam int N_PAIRS = 68;
  localparam int N_SECTIONS = 4;
  localparam int N_GAINS = 5;
  localparam int COEF_WORDS = 25;
  localparam int COEF_BYTES = 100;
  localparam int BQ_LAST_STEP = 8;

  localparam int GROUP_DELAY_OUTPUTS = 34;
  localparam int SETTLE_OUTPUTS = 68;
  localparam int UNSETTLED_AFTER_STEP = 69;
  localparam logic [6:0] SETTLE_COUNT = 7'h44;
  localparam logic [4:0] SYNC_OVERHEAD_CLKS = 5'h10;
  localparam logic [4:0] BUF_OVERHEAD_CLKS = 5'h08;

  localparam logic [6:0] ADDR_STATUS_PRIMARY = 7'h01;
  localparam logic [6:0] ADDR_FILTER_CFG_PRI = 7'h03;
  localparam logic [6:0] ADDR_FILTER_CFG_SEC = 7'h04;
  localparam logic [6:0] ADDR_COEF_WINDOW = 7'h16;

  localparam logic [2:0] SEL_DEFAULT = 3'h0;
  localparam logic [2:0] SEL_USER = 3'h7;
  localparam logic [2:0] FCP_RESET = 3'h0;
  localparam logic FCS_IIR_STAGE_DISABLE_RESET = 1'b1;
  localparam logic FCS_IIR_AFTER_RESET = 1'b0;

  localparam logic [4:0] SPI_HDR_LAST = 5'h07;
  localparam logic [4:0] SPI_FRAME_LAST = 5'h0F;
  localparam logic [4:0] SPI_FRAME_BITS = 5'h10;

  localparam logic [31:0] COEF_ONE = 32'h40000000;
  localparam logic [31:0] COEF_ZERO = 32'h00000000;
  // Flat tap weight, about 1/136 in 1.31, sums to near unity
  localparam logic [31:0] DEFAULT_TAP = 32'h00F0F0F1;

  localparam logic signed [63:0] SAT_MAX = 64'sh00000000007FFFFF;
  localparam logic signed [63:0] SAT_MIN = 64'shFFFFFFFFFF800000;

  function automatic logic signed [DATA_W-1:0] sat_round(
    input logic signed [63:0] acc,
    input int unsigned shift
  );
    logic signed [63:0] r;
    r = (acc + (64'sh1 <<< (shift - 1))) >>> shift;
    if (r > SAT_MAX)
    begin
      return SAT_MAX[DATA_W-1:0];
    end
    if (r < SAT_MIN)
    begin
      return SAT_MIN[DATA_W-1:0];
    end
    return r[DATA_W-1:0];
  endfunction

endpackage

// ---- wbfbq_bq_if.sv ----
/*
  Link between the filter top and its biquad engine.
  Assumes both ends run on the same master clock.
*/
`timescale 1ns/100ps
interface wbfbq_bq_if;
  import wbfbq_pkg::*;
  logic start;
  logic clear;
  logic signed [DATA_W-1:0] x;
  logic done;
  logic signed [DATA_W-1:0] y;
  logic [COEF_W-1:0] coef [COEF_WORDS];

  modport ctrl (output start, clear, x, coef, input done, y);
  modport engine (input start, clear, x, coef, output done, y);
endinterface

// ---- wbfbq_biquad.sv ----
/*
  Four-section direct-form-one biquad cascade with five gains, one step
  per clock: g1, H1, g2, H2, g3, H3, g4, H4, g5.
  Assumes a new sample arrives no sooner than ten clocks after the last.
*/
`timescale 1ns/100ps
module wbfbq_biquad
  import wbfbq_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  wbfbq_bq_if.engine bq
);

  logic [3:0] step_reg;
  logic busy_reg;
  logic signed [DATA_W-1:0] v_reg;
  logic signed [DATA_W-1:0] xh_reg [N_SECTIONS][2];
  logic signed [DATA_W-1:0] yh_reg [N_SECTIONS][2];
  logic signed [DATA_W-1:0] v_next;
  int unsigned sec;
  int unsigned base;
  logic signed [63:0] acc;

  ////////////////////////////////////////////////////////////////////////
  // One gain or one section per step, saturated with rounding

  always_comb
  begin
    sec = 32'(step_reg) / 2;
    base = 25 - 6 * (sec + 1);
    acc = '0;
    if (!step_reg[0])
    begin
      acc = 64'(signed'(bq.coef[24 - 3 * 32'(step_reg)])) * 64'(v_reg);
    end
    else
    begin
      // b0 x + b1 x1 + b2 x2 - a1 y1 - a2 y2
      acc = 64'(signed'(bq.coef[base + 4])) * 64'(v_reg)
          + 64'(signed'(bq.coef[base + 3])) * 64'(xh_reg[sec][0])
          + 64'(signed'(bq.coef[base + 2])) * 64'(xh_reg[sec][1])
          - 64'(signed'(bq.coef[base + 1])) * 64'(yh_reg[sec][0])
          - 64'(signed'(bq.coef[base])) * 64'(yh_reg[sec][1]);
    end
    v_next = sat_round(acc, IIR_FRAC);
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer and section history

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      step_reg <= 4'h0;
      busy_reg <= 1'b0;
      v_reg <= '0;
      bq.done <= 1'b0;
      bq.y <= '0;
      for (int i = 0; i < N_SECTIONS; i++)
      begin
        xh_reg[i][0] <= '0;
        xh_reg[i][1] <= '0;
        yh_reg[i][0] <= '0;
        yh_reg[i][1] <= '0;
      end
    end
    else
    begin
      bq.done <= 1'b0;
      if (bq.clear)
      begin
        busy_reg <= 1'b0;
        step_reg <= 4'h0;
        for (int i = 0; i < N_SECTIONS; i++)
        begin
          xh_reg[i][0] <= '0;
          xh_reg[i][1] <= '0;
          yh_reg[i][0] <= '0;
          yh_reg[i][1] <= '0;
        end
      end
      else if (bq.start && !busy_reg)
      begin
        busy_reg <= 1'b1;
        step_reg <= 4'h0;
        v_reg <= bq.x;
      end
      else if (busy_reg)
      begin
        v_reg <= v_next;
        if (step_reg[0])
        begin
          xh_reg[sec][0] <= v_reg;
          xh_reg[sec][1] <= xh_reg[sec][0];
          yh_reg[sec][0] <= v_next;
          yh_reg[sec][1] <= yh_reg[sec][0];
        end
        if (step_reg == 4'(BQ_LAST_STEP))
        begin
          busy_reg <= 1'b0;
          bq.done <= 1'b1;
          bq.y <= v_next;
        end
        else
        begin
          step_reg <= step_reg + 4'h1;
        end
      end
    end
  end

endmodule

// ---- wbfbq_top.sv ----
/*
  Final wideband decimator (136-tap symmetric, decimate by two) with an
  optional biquad stage, SPI register access and a coefficient window.
  Assumes upstream samples arrive at least 35 clocks apart and the SPI
  clock is slow enough to be sampled by the master clock.
*/
`timescale 1ns/100ps

// Behaviour
// - Select code zero uses built-in coefficients
// - Select code all-ones uses user coefficients
// - Group delay is 34 output periods
// - Step settles after 68 output periods
// - Synchronization clears filter state and restarts
// - Withhold first 68 results after restart
// - Sixteen clock overhead on result latency
// - Unsynchronized step gives 69 unsettled results
// - Band edges 0.4125 and 0.4374 of rate
// - Buffers enabled add eight clock periods
// - Four biquad sections with five gains
// - Disable bit bypasses biquad, disabled at reset
// - Biquad placed before or after decimator
// - Sections computed in direct form one
// - Coefficients are signed 2.30, 32 bits
// - One window address reaches 100-byte store
// - Pointer advances after each window access
// - Bytes MSB first, g5 first, g1 last
// - Other register access resets byte pointer
// - Clearing serial error restarts coefficient sequence
// - Reset store is unity-gain all-pass
module wbfbq_top
  import wbfbq_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic CS_N,
  input wire logic SCLK,
  input wire logic SDI,
  output logic SDO,
  output logic SDO_OE_N,
  input wire logic SYNC,
  input wire logic CRC_ERR,
  input wire logic ANALOG_BUF_EN,
  input wire logic DIN_VALID,
  input wire logic signed [DATA_W-1:0] DIN,
  output logic [5:0] USER_COEF_IDX,
  input wire logic [COEF_W-1:0] USER_COEF_A,
  input wire logic [COEF_W-1:0] USER_COEF_B,
  output logic DOUT_VALID,
  output logic signed [DATA_W-1:0] DOUT
);

  typedef enum {WBFBQ_IDLE, WBFBQ_MAC, WBFBQ_ROUND} wbfbq_fir_t;

  wbfbq_bq_if bq ();

  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic sclk_prev_reg;
  logic cs_n_s;
  logic sclk_s;
  logic sdi_s;
  logic sclk_rise;
  logic sclk_fall;
  logic [4:0] bit_cnt_reg;
  logic [15:0] shift_reg;
  logic [7:0] tx_reg;
  logic frame_done_reg;
  logic [7:0] rd_value;
  logic fr_read;
  logic [6:0] fr_addr;
  logic [7:0] fr_data;
  logic [2:0] sel_reg;
  logic iir_stage_disable_reg;
  logic iir_after_reg;
  logic spi_err_reg;
  logic [6:0] ptr_reg;
  logic [COEF_W-1:0] coef_reg [COEF_WORDS];
  logic signed [DATA_W-1:0] dl_reg [N_TAPS];
  logic phase_reg;
  wbfbq_fir_t fir_state_reg;
  logic signed [63:0] acc_reg;
  logic fir_done_reg;
  logic signed [DATA_W-1:0] fir_y_reg;
  logic [6:0] settle_reg;
  logic [4:0] ovh_reg;
  logic ovh_busy_reg;
  logic signed [DATA_W-1:0] hold_reg;
  logic fir_in_valid;
  logic signed [DATA_W-1:0] fir_in;
  logic post_valid;
  logic signed [DATA_W-1:0] post_data;
  logic signed [COEF_W-1:0] coef_a;
  logic signed [COEF_W-1:0] coef_b;
  logic signed [DATA_W:0] pair_a;
  logic signed [DATA_W:0] pair_b;
  logic [5:0] idx;
  logic iir_on;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronizers; only the second stage is looked at

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      sync1_reg <= 3'h1;
      sync2_reg <= 3'h1;
      sclk_prev_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= {SDI, SCLK, CS_N};
      sync2_reg <= sync1_reg;
      sclk_prev_reg <= sync2_reg[1];
    end
  end

  assign cs_n_s = sync2_reg[0];
  assign sclk_s = sync2_reg[1];
  assign sdi_s = sync2_reg[2];
  assign sclk_rise = sclk_s && !sclk_prev_reg;
  assign sclk_fall = !sclk_s && sclk_prev_reg;

  ////////////////////////////////////////////////////////////////////////
  // SPI frame: read flag, 7-bit address, 8-bit data, MSB first

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      bit_cnt_reg <= 5'h00;
      shift_reg <= 16'h0000;
      tx_reg <= 8'h00;
      frame_done_reg <= 1'b0;
      SDO <= 1'b0;
      SDO_OE_N <= 1'b1;
    end
    else
    begin
      frame_done_reg <= 1'b0;
      SDO_OE_N <= cs_n_s;
      if (cs_n_s)
      begin
        bit_cnt_reg <= 5'h00;
        SDO <= 1'b0;
      end
      else if (sclk_rise && bit_cnt_reg != SPI_FRAME_BITS)
      begin
        shift_reg <= {shift_reg[14:0], sdi_s};
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
        if (bit_cnt_reg == SPI_HDR_LAST)
        begin
          tx_reg <= rd_value;
        end
        if (bit_cnt_reg == SPI_FRAME_LAST)
        begin
          frame_done_reg <= 1'b1;
        end
      end
      else if (sclk_fall && bit_cnt_reg > SPI_HDR_LAST &&
               bit_cnt_reg != SPI_FRAME_BITS)
      begin
        SDO <= tx_reg[7];
        tx_reg <= {tx_reg[6:0], 1'b0};
      end
    end
  end

  assign fr_read = shift_reg[15];
  assign fr_addr = shift_reg[14:8];
  assign fr_data = shift_reg[7:0];

  // Read data is fetched as the address byte completes
  always_comb
  begin
    case ({shift_reg[5:0], sdi_s})
      ADDR_STATUS_PRIMARY: rd_value = {6'h00, settle_reg == 7'h00,
                                       spi_err_reg};
      ADDR_FILTER_CFG_PRI: rd_value = {5'h00, sel_reg};
      ADDR_FILTER_CFG_SEC: rd_value = {6'h00, iir_after_reg, iir_stage_disable_reg};
      ADDR_COEF_WINDOW: rd_value = coef_reg[ptr_reg[6:2]]
                                   [8 * (3 - ptr_reg[1:0]) +: 8];
      default: rd_value = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Control registers; frame handling is one clock, so ten-clock
  // spacing between coefficient frames is ample

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      sel_reg <= FCP_RESET;
      iir_stage_disable_reg <= FCS_IIR_STAGE_DISABLE_RESET;
      iir_after_reg <= FCS_IIR_AFTER_RESET;
      spi_err_reg <= 1'b0;
    end
    else
    begin
      if (frame_done_reg && !fr_read)
      begin
        if (fr_addr == ADDR_FILTER_CFG_PRI)
        begin
          sel_reg <= fr_data[2:0];
        end
        if (fr_addr == ADDR_FILTER_CFG_SEC)
        begin
          iir_stage_disable_reg <= fr_data[0];
          iir_after_reg <= fr_data[1];
        end
      end
      // A new error wins over a clear in the same clock
      if (CRC_ERR)
      begin
        spi_err_reg <= 1'b1;
      end
      else if (frame_done_reg && !fr_read &&
               fr_addr == ADDR_STATUS_PRIMARY && fr_data[0])
      begin
        spi_err_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Coefficient store behind the window and its byte pointer

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      ptr_reg <= 7'h00;
      for (int w = 0; w < COEF_WORDS; w++)
      begin
        coef_reg[w] <= (w % 6 == 0 || w % 6 == 5) ? COEF_ONE
                                                    : COEF_ZERO;
      end
    end
    else if (frame_done_reg)
    begin
      if (fr_addr == ADDR_COEF_WINDOW)
      begin
        if (!fr_read)
        begin
          coef_reg[ptr_reg[6:2]][8 * (3 - ptr_reg[1:0]) +: 8]
            <= fr_data;
        end
        ptr_reg <= (ptr_reg == 7'(COEF_BYTES - 1)) ? 7'h00
                                                   : ptr_reg + 7'h01;
      end
      else if (fr_addr == ADDR_STATUS_PRIMARY && !fr_read && fr_data[0])
      begin
        ptr_reg <= 7'h00;
      end
      else
      begin
        ptr_reg <= 7'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Stage ordering around the single biquad engine

  assign iir_on = !iir_stage_disable_reg;
  assign bq.coef = coef_reg;
  assign bq.clear = SYNC;
  assign bq.start = iir_on && (iir_after_reg ? fir_done_reg
                                             : DIN_VALID);
  assign bq.x = iir_after_reg ? fir_y_reg : DIN;
  assign fir_in_valid = (iir_on && !iir_after_reg) ? bq.done : DIN_VALID;
  assign fir_in = (iir_on && !iir_after_reg) ? bq.y : DIN;
  assign post_valid = (iir_on && iir_after_reg) ? bq.done : fir_done_reg;
  assign post_data = (iir_on && iir_after_reg) ? bq.y : fir_y_reg;

  wbfbq_biquad u_biquad (
    .clk(CLK),
    .rst_n(RSTN),
    .bq(bq)
  );

  ////////////////////////////////////////////////////////////////////////
  // Symmetric decimator: two folded tap pairs per clock, 34 clocks

  assign idx = USER_COEF_IDX;
  assign pair_a = (DATA_W + 1)'(dl_reg[2 * idx]) +
                  (DATA_W + 1)'(dl_reg[N_TAPS - 1 - 2 * idx]);
  assign pair_b = (DATA_W + 1)'(dl_reg[2 * idx + 1]) +
                  (DATA_W + 1)'(dl_reg[N_TAPS - 2 - 2 * idx]);
  assign coef_a = (sel_reg == SEL_USER) ? USER_COEF_A : DEFAULT_TAP;
  assign coef_b = (sel_reg == SEL_USER) ? USER_COEF_B : DEFAULT_TAP;

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      for (int k = 0; k < N_TAPS; k++)
      begin
        dl_reg[k] <= '0;
      end
      phase_reg <= 1'b0;
    end
    else if (SYNC)
    begin
      for (int k = 0; k < N_TAPS; k++)
      begin
        dl_reg[k] <= '0;
      end
      phase_reg <= 1'b0;
    end
    else if (fir_in_valid)
    begin
      dl_reg[0] <= fir_in;
      for (int k = 1; k < N_TAPS; k++)
      begin
        dl_reg[k] <= dl_reg[k - 1];
      end
      phase_reg <= !phase_reg;
    end
  end

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      fir_state_reg <= WBFBQ_IDLE;
      acc_reg <= '0;
      USER_COEF_IDX <= 6'h00;
      fir_done_reg <= 1'b0;
      fir_y_reg <= '0;
    end
    else
    begin
      fir_done_reg <= 1'b0;
      if (SYNC)
      begin
        fir_state_reg <= WBFBQ_IDLE;
        USER_COEF_IDX <= 6'h00;
      end
      else
      begin
        case (fir_state_reg)
          WBFBQ_IDLE:
          begin
            if (fir_in_valid && phase_reg)
            begin
              acc_reg <= '0;
              USER_COEF_IDX <= 6'h00;
              fir_state_reg <= WBFBQ_MAC;
            end
          end
          WBFBQ_MAC:
          begin
            acc_reg <= acc_reg + 64'(coef_a) * 64'(pair_a)
                               + 64'(coef_b) * 64'(pair_b);
            if (USER_COEF_IDX == 6'(N_PAIRS / 2 - 1))
            begin
              fir_state_reg <= WBFBQ_ROUND;
            end
            else
            begin
              USER_COEF_IDX <= USER_COEF_IDX + 6'h01;
            end
          end
          WBFBQ_ROUND:
          begin
            fir_y_reg <= sat_round(acc_reg, FIR_FRAC);
            fir_done_reg <= 1'b1;
            USER_COEF_IDX <= 6'h00;
            fir_state_reg <= WBFBQ_IDLE;
          end
          default:
          begin
            fir_state_reg <= WBFBQ_IDLE;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Result suppression after restart and fixed output overhead.
  // Without a restart results keep flowing, so an input step shows as
  // unsettled values for a while; the host has to allow for that.

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      settle_reg <= SETTLE_COUNT;
      ovh_reg <= 5'h00;
      ovh_busy_reg <= 1'b0;
      hold_reg <= '0;
      DOUT_VALID <= 1'b0;
      DOUT <= '0;
    end
    else
    begin
      DOUT_VALID <= 1'b0;
      if (SYNC)
      begin
        settle_reg <= SETTLE_COUNT;
        ovh_busy_reg <= 1'b0;
      end
      else
      begin
        if (post_valid)
        begin
          if (settle_reg != 7'h00)
          begin
            settle_reg <= settle_reg - 7'h01;
          end
          else
          begin
            hold_reg <= post_data;
            ovh_busy_reg <= 1'b1;
            ovh_reg <= ANALOG_BUF_EN
                       ? SYNC_OVERHEAD_CLKS + BUF_OVERHEAD_CLKS
                       : SYNC_OVERHEAD_CLKS;
          end
        end
        else if (ovh_busy_reg)
        begin
          if (ovh_reg == 5'h01)
          begin
            ovh_busy_reg <= 1'b0;
            DOUT_VALID <= 1'b1;
            DOUT <= hold_reg;
          end
          ovh_reg <= ovh_reg - 5'h01;
        end
      end
    end
  end

endmodule

// ---- wbfbq_chk.sv ----
/*
  Port-level assertions for wbfbq_top: result suppression, latency
  overhead, result pulse and idle SPI lines.
  Assumes samples arrive in pairs counted from reset or SYNC.
*/
`timescale 1ns/100ps
module wbfbq_chk
  import wbfbq_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic CS_N,
  input wire logic SDO,
  input wire logic SDO_OE_N,
  input wire logic SYNC,
  input wire logic ANALOG_BUF_EN,
  input wire logic DIN_VALID,
  input wire logic [5:0] USER_COEF_IDX,
  input wire logic DOUT_VALID,
  input wire logic signed [DATA_W-1:0] DOUT
);
  logic [7:0] din_cnt;
  logic [7:0] since_pair;
  logic odd;

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      din_cnt <= 8'h00;
      odd <= 1'b0;
    end
    else if (SYNC)
    begin
      din_cnt <= 8'h00;
      odd <= 1'b0;
    end
    else if (DIN_VALID)
    begin
      din_cnt <= (din_cnt == 8'hFF) ? din_cnt : din_cnt + 8'h01;
      odd <= !odd;
    end
  end

  // Saturates so a long idle spell never wraps to a small value
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      since_pair <= 8'hFF;
    end
    else if (DIN_VALID && odd && !SYNC)
    begin
      since_pair <= 8'h00;
    end
    else if (since_pair != 8'hFF)
    begin
      since_pair <= since_pair + 8'h01;
    end
  end

  ////////////////////////////////////////
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);

  AST_SUPPRESS: assert property (DOUT_VALID |-> din_cnt >= 8'h8A)
    else $error("result reported before settling");
  AST_SYNC_QUIET: assert property (SYNC |=> !DOUT_VALID [*8])
    else $error("result right after restart");
  AST_OVERHEAD: assert property (DOUT_VALID |-> since_pair >= 8'h34)
    else $error("result overhead too short");
  AST_BUF_EXTRA: assert property (
    DOUT_VALID && ANALOG_BUF_EN |-> since_pair >= 8'h3C)
    else $error("buffer overhead missing");
  AST_PULSE: assert property (DOUT_VALID |=> !DOUT_VALID)
    else $error("data ready longer than one cycle");
  AST_HOLD: assert property (!DOUT_VALID |-> $stable(DOUT))
    else $error("result changed without data ready");
  AST_SDO_IDLE: assert property (CS_N [*5] |-> !SDO)
    else $error("serial output active while deselected");
  AST_OE_IDLE: assert property (CS_N [*5] |-> SDO_OE_N)
    else $error("serial output enabled while deselected");
  AST_IDX: assert property (USER_COEF_IDX <= 6'h21)
    else $error("user tap index out of range");

  cover property (DOUT_VALID);
  cover property (DOUT_VALID && ANALOG_BUF_EN);
  cover property (!SDO_OE_N);
endmodule

bind wbfbq_top wbfbq_chk wbfbq_chk_i (.CLK(CLK), .RSTN(RSTN),
  .CS_N(CS_N), .SDO(SDO), .SDO_OE_N(SDO_OE_N), .SYNC(SYNC),
  .ANALOG_BUF_EN(ANALOG_BUF_EN), .DIN_VALID(DIN_VALID),
  .USER_COEF_IDX(USER_COEF_IDX), .DOUT_VALID(DOUT_VALID), .DOUT(DOUT));

// ---- wbfbq_host.sv ----
/*
  Host controller model: 16-bit SPI frames to the register bus.
  Assumes a 20 ns master clock; lines change on falling CLK edges.
*/
`timescale 1ns/100ps
module wbfbq_host
(
  input wire logic clk,
  input wire logic sdo,
  output logic cs_n,
  output logic sclk,
  output logic sdi
);
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end

  ////////////////////////////////////////
  // Four clocks per phase: the device samples SCLK through two flops
  task automatic xfer(input logic [15:0] frm, output logic [7:0] rd);
    rd = 8'h00;
    @(negedge clk);
    cs_n = 1'b0;
    repeat (4) @(negedge clk);
    for (int i = 15; i >= 0; i--)
    begin
      sdi = frm[i];
      repeat (4) @(negedge clk);
      sclk = 1'b1;
      rd = {rd[6:0], sdo};
      repeat (4) @(negedge clk);
      sclk = 1'b0;
    end
    repeat (4) @(negedge clk);
    cs_n = 1'b1;
    sdi = !sdi;
    repeat (12) @(negedge clk);
  endtask
endmodule

// ---- tb_wbfbq_top.sv ----
/*
  Self-checking bench for wbfbq_top: registers, coefficient window,
  suppression, latency and the biquad path.
  Assumes wbfbq_host makes the SPI frames.
*/
`timescale 1ns/100ps
`define CHK(g, e) \
  begin \
    checks++; \
    if ((g) !== (e)) \
    begin \
      mismatches++; \
      $display("unexpected at %0t: %h vs %h", $time, (g), (e)); \
    end \
  end
module tb_wbfbq_top
  import wbfbq_pkg::*;
;
  logic clk = 1'b0, rstn = 1'b0, sync = 1'b0, crc = 1'b0;
  logic abuf = 1'b0, din_valid = 1'b0, cs_n, sclk, sdi, sdo, oe_n;
  logic signed [DATA_W-1:0] din = 24'h000000, dout;
  logic signed [DATA_W-1:0] outv [0:255];
  logic [5:0] idx;
  logic [COEF_W-1:0] ua;
  logic dout_valid;
  wire sdo_line = oe_n ? !sdo : sdo;
  int mismatches = 0, checks = 0, nout = 0, cyc = 0, tin, tout, lat0;

  always #10 clk = !clk;
  always @(posedge clk) cyc <= cyc + 1;
  always @(posedge clk)
  begin
    if (dout_valid)
    begin
      outv[nout] <= dout;
      tout <= cyc;
      nout <= nout + 1;
    end
  end
  // External bank: only the outer tap pair is used, one quarter each, so
  // a settled input comes out halved and differs from the built-in set
  assign ua = (idx == 6'h00) ? 32'h20000000 : 32'h00000000;

  wbfbq_top wbfbq_top_i (.CLK(clk), .RSTN(rstn), .CS_N(cs_n),
    .SCLK(sclk), .SDI(sdi), .SDO(sdo), .SDO_OE_N(oe_n), .SYNC(sync),
    .CRC_ERR(crc), .ANALOG_BUF_EN(abuf), .DIN_VALID(din_valid),
    .DIN(din), .USER_COEF_IDX(idx), .USER_COEF_A(ua),
    .USER_COEF_B(32'h00000000), .DOUT_VALID(dout_valid), .DOUT(dout));
  wbfbq_host wbfbq_host_i (.clk(clk), .sdo(sdo_line), .cs_n(cs_n),
    .sclk(sclk), .sdi(sdi));

  ////////////////////////////////////////
  function automatic logic [7:0] exp_byte(input int i, input logic [7:0] h);
    logic [31:0] w;
    w = ((i / 4) inside {0, 5, 6, 11, 12, 17, 18, 23, 24}) ?
      COEF_ONE : COEF_ZERO;
    if (i < 4)
    begin
      w[31:24] = h;
    end
    return w[31 - 8 * (i % 4) -: 8];
  endfunction

  task automatic rd(input logic [6:0] a, input logic [7:0] m,
    input logic [7:0] e);
    logic [7:0] v;
    wbfbq_host_i.xfer({1'b1, a, 8'h00}, v);
    `CHK(v & m, e)
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] v;
    wbfbq_host_i.xfer({1'b0, a, d}, v);
  endtask

  task automatic feed(input logic signed [DATA_W-1:0] v, input int n);
    repeat (n)
    begin
      @(negedge clk);
      din = v;
      din_valid = 1'b1;
      tin = cyc;
      @(negedge clk);
      din_valid = 1'b0;
      repeat (38) @(negedge clk);
    end
    repeat (40) @(negedge clk);
  endtask

  task automatic resync();
    @(negedge clk);
    sync = 1'b1;
    @(negedge clk);
    sync = 1'b0;
  endtask

  task automatic final_report();
    if (mismatches == 0 && checks > 0)
    begin
      $display("No errors found");
    end
    else
    begin
      $display("Errors were found");
    end
    $finish;
  endtask

  ////////////////////////////////////////
  initial
  begin
    repeat (75000) @(posedge clk);
    mismatches++;
    final_report();
  end

  initial
  begin
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    rd(ADDR_FILTER_CFG_PRI, 8'h07, {5'h00, SEL_DEFAULT});
    rd(ADDR_FILTER_CFG_SEC, 8'h03, 8'h01);
    for (int i = 0; i < COEF_BYTES; i++)
    begin
      rd(ADDR_COEF_WINDOW, 8'hFF, exp_byte(i, 8'h40));
    end
    rd(ADDR_COEF_WINDOW, 8'hFF, 8'h40);
    rd(ADDR_FILTER_CFG_PRI, 8'h07, {5'h00, SEL_DEFAULT});
    rd(ADDR_COEF_WINDOW, 8'hFF, 8'h40);
    @(negedge clk);
    crc = 1'b1;
    @(negedge clk);
    crc = 1'b0;
    rd(ADDR_STATUS_PRIMARY, 8'h01, 8'h01);
    wr(ADDR_STATUS_PRIMARY, 8'h01);
    rd(ADDR_STATUS_PRIMARY, 8'h01, 8'h00);
    for (int i = 0; i < COEF_BYTES; i++)
    begin
      wr(ADDR_COEF_WINDOW, exp_byte(i, 8'h20));
    end
    for (int i = 0; i < 8; i++)
    begin
      rd(ADDR_COEF_WINDOW, 8'hFF, exp_byte(i, 8'h20));
    end
    resync();
    feed(24'h100000, 136);
    `CHK(nout, 0)
    feed(24'h100000, 2);
    `CHK(nout, 1)
    `CHK(outv[0], 24'h100000)
    lat0 = tout - tin;
    feed(24'h200000, 136);
    `CHK(outv[34], 24'h180000)
    `CHK(outv[67] === 24'h200000, 1'b0)
    `CHK(outv[68], 24'h200000)
    abuf = 1'b1;
    feed(24'h200000, 2);
    `CHK(tout - tin - lat0, 8)
    abuf = 1'b0;
    wr(ADDR_FILTER_CFG_SEC, 8'h00);
    resync();
    feed(24'h200000, 138);
    `CHK(outv[nout - 1], 24'h100000)
    wr(ADDR_FILTER_CFG_SEC, 8'h02);
    resync();
    feed(24'h200000, 138);
    `CHK(outv[nout - 1], 24'h100000)
    wr(ADDR_FILTER_CFG_SEC, 8'h01);
    wr(ADDR_FILTER_CFG_PRI, {5'h00, SEL_USER});
    resync();
    feed(24'h200000, 138);
    `CHK(outv[nout - 1], 24'h100000)
    final_report();
  end
endmodule
